// [hdl/acl_pkg.sv]
// constants and carrier types for the acl classifier stage
package acl_pkg;
    // sizes
    localparam int NUM_PORTS = 11;
    localparam int COMMON_W = 44;
    localparam int KEY_W = 374;
    localparam int ACT_W = 31;
    localparam int IDX_W = 6;
    localparam int FRAME_BYTES = 96;
    localparam int CUSTOM_BYTES = 40;
    localparam int HIT_W = 8;
    localparam int PORT_W = 4;
    localparam int SLOT_W = 7;
    localparam int NUM_SLOTS = (2 ** IDX_W) + NUM_PORTS + 1;
    localparam int SLOT_DEF_PORT = 2 ** IDX_W;
    localparam int SLOT_DEF_COMMON = (2 ** IDX_W) + NUM_PORTS;
    // ipv6 generic key layout
    localparam int KEY_TTL_BIT = 44;
    localparam int KEY_TOS_LSB = 45;
    localparam int KEY_DIP_LSB = 53;
    localparam int KEY_SIP_LSB = 181;
    localparam int KEY_EQ_BIT = 309;
    localparam int KEY_NXT_LSB = 310;
    localparam int KEY_L4_LSB = 318;
    localparam int KEY_L4_W = 56;
    // custom key layout
    localparam int KEY_CUST_SEL_BIT = 44;
    localparam int KEY_CUST_LSB = 45;
    localparam int KEY_CUST_W = 320;
    localparam logic [6:0] OFS_AFTER_L3 = 7'h22;
    localparam logic [6:0] OFS_AFTER_SMAC = 7'h0C;
    localparam int VLAN_TAG_BYTES = 4;
    // action layout
    localparam int ACT_ONCE_BIT = 0;
    localparam int ACT_COPY_BIT = 1;
    localparam int ACT_QU_LSB = 2;
    localparam int CPU_Q_W = 3;
    localparam int ACT_MODE_LSB = 5;
    localparam int ACT_MIRROR_BIT = 7;
    localparam int ACT_LRN_BIT = 8;
    localparam int ACT_POL_BIT = 9;
    localparam int ACT_PIDX_LSB = 10;
    localparam int PIDX_W = 9;
    localparam int ACT_MASK_LSB = 20;
    // mask modes
    localparam logic [1:0] MM_NONE = 2'h0;
    localparam logic [1:0] MM_PERMIT = 2'h1;
    localparam logic [1:0] MM_POLICY = 2'h2;
    localparam logic [1:0] MM_REDIRECT = 2'h3;
    // apb register map
    localparam int APB_AW = 8;
    localparam logic [7:0] REG_MIRROR = 8'h00;
    localparam logic [7:0] REG_DEF_COMMON = 8'h04;
    localparam logic [7:0] REG_HIT_SEL = 8'h08;
    localparam logic [7:0] REG_ENTRY_HIT_COUNTER = 8'h0C;
    localparam logic [7:0] REG_FRAMES = 8'h10;
    localparam logic [7:0] REG_DEF_PORT_BASE = 8'h40;
    localparam logic [7:0] REG_DEF_PORT_END = 8'h6C;
    // frame from the analyzer
    typedef struct packed {
        logic [COMMON_W-1:0] common;
        logic use_custom;
        logic after_source_mac_offset;
        logic [1:0] vlan_tags;
        logic [PORT_W-1:0] ingress_port;
        logic [7:0] hop_limit;
        logic [7:0] traffic_class;
        logic [127:0] dip;
        logic [127:0] sip;
        logic [7:0] next_header;
        logic [KEY_L4_W-1:0] l4_bytes;
        logic [FRAME_BYTES*8-1:0] bytes;
        logic [NUM_PORTS-1:0] dmac_set;
        logic [NUM_PORTS-1:0] prior_set;
        logic cpu_member;
    } acl_frame_type;
    // answer of one lookup
    typedef struct packed {
        logic hit;
        logic [IDX_W-1:0] index;
        logic [ACT_W-1:0] action;
    } acl_rsp_type;
    // forwarding decision
    typedef struct packed {
        logic [NUM_PORTS-1:0] dest_set;
        logic cpu_member;
        logic cpu_copy;
        logic [CPU_Q_W-1:0] cpu_queue;
        logic [NUM_PORTS-1:0] mirror_ports;
        logic learning_inhibit;
        logic police_en;
        logic [PIDX_W-1:0] policer_select;
    } acl_dec_type;
endpackage : acl_pkg

// [hdl/acl_key_action_decode.sv]
// acl classifier stage: key build, two lookups, action decode
//
// How it works
// R1: ipv6 key bit 44 is hop limit nonzero, traffic class from bit 45.
// R2: destination address from bit 53, source from 181, equality flag at 309.
// R3: next header from bit 310, seven bytes after ip header from 318.
// R4: custom selector zero takes raw bytes from frame byte 34.
// R5: selector one takes bytes from frame byte 12; 320 bits at key 45.
// R6: up to three vlan tags skipped before custom extraction.
// R7: two sequential lookups per frame, each giving its own action.
// R8: first lookup miss uses per ingress port default action.
// R9: second lookup miss uses one common default action.
// R10: default actions are decoded exactly like matched actions.
// R11: single-shot copies to cpu only while hit counter zero, then counts.
// R12: later hits not copied until software clears the hit counter.
// R13: copy-all bit copies every hitting frame to the cpu queue.
// R14: three-bit field at bit 2 selects the cpu queue.
// R15: mask mode 0 leaves forwarding, mode 1 ands the port set.
// R16: mask mode 2 replaces the dmac lookup result with the port set.
// R17: mask mode 3 replaces all earlier forwarding with the port set.
// R18: cpu port membership untouched by every mask mode.
// R19: bit 7 sends a mirror copy to the mirror target ports.
// R20: bit 8 suppresses learning for hitting frames.
// R21: bit 9 polices with the named policer, first lookup only.
// R22: policer index is the nine-bit field at bit 10.
// R23: port set is the eleven-bit field at bit 20.
`timescale 1ns/100ps
module acl_key_action_decode
    import acl_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // frame from analyzer
    input wire logic frm_valid_in,
    input wire acl_frame_type frm_in,
    output logic frm_ready_out,
    // lookup engine
    output logic lkp_req_out,
    output logic lkp_first_out,
    output logic [KEY_W-1:0] lkp_key_out,
    input wire logic lkp_rsp_valid_in,
    input wire acl_rsp_type lkp_rsp_in,
    // decision to forwarding
    output logic dec_valid_out,
    output acl_dec_type dec_out,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [APB_AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_REQ1, ST_WAIT1, ST_REQ2, ST_WAIT2, ST_DONE
    } acl_state_type;

    acl_state_type state_q, state_d;
    acl_frame_type frm_q;
    logic rdy_q;
    logic req_q;
    logic first_q;
    logic [KEY_W-1:0] key_q;
    logic [ACT_W-1:0] act1_q, act2_q;
    logic copy1_q, copy2_q;
    logic dec_valid_q;
    acl_dec_type dec_q;
    logic [NUM_PORTS-1:0] mirror_q;
    logic [ACT_W-1:0] def_common_q;
    logic [ACT_W-1:0] def_port_q [NUM_PORTS];
    logic [SLOT_W-1:0] hit_sel_q;
    logic [HIT_W-1:0] entry_hit_counter_q [NUM_SLOTS];
    logic [31:0] frames_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;

    // key construction
    wire logic ttl_gt0 = frm_q.hop_limit != 8'h00;
    wire logic addr_eq = frm_q.dip == frm_q.sip;
    wire logic [6:0] cust_base = frm_q.after_source_mac_offset ? OFS_AFTER_SMAC : OFS_AFTER_L3; // R4 R5
    wire logic [6:0] cust_skip = {3'h0, frm_q.vlan_tags, 2'h0}; // R6
    wire logic [6:0] cust_start = cust_base + cust_skip; // R6
    logic [KEY_CUST_W-1:0] cust_data;
    logic [KEY_W-1:0] key_ip6, key_cust;

    genvar g;
    generate
        for (g = 0; g < CUSTOM_BYTES; g++)
        begin : g_cust
            assign cust_data[g*8 +: 8] = frm_q.bytes[(int'(cust_start) + g) * 8 +: 8]; // R5
        end
    endgenerate

    assign key_ip6 = {frm_q.l4_bytes, frm_q.next_header, addr_eq, frm_q.sip, frm_q.dip,
        frm_q.traffic_class, ttl_gt0, frm_q.common}; // R1 R2 R3
    assign key_cust = {{(KEY_W - KEY_CUST_LSB - KEY_CUST_W){1'b0}}, cust_data,
        frm_q.after_source_mac_offset, frm_q.common}; // R4 R5
    wire logic [KEY_W-1:0] key_sel = frm_q.use_custom ? key_cust : key_ip6;

    // lookup answer and default selection
    wire logic waiting = (state_q == ST_WAIT1) || (state_q == ST_WAIT2);
    wire logic rsp_take = waiting && lkp_rsp_valid_in;
    wire logic rsp_first = state_q == ST_WAIT1;
    wire logic [ACT_W-1:0] def_act = rsp_first ? def_port_q[frm_q.ingress_port]
        : def_common_q; // R8 R9
    wire logic [ACT_W-1:0] rsp_act = lkp_rsp_in.hit ? lkp_rsp_in.action : def_act; // R10
    wire logic [SLOT_W-1:0] def_slot = rsp_first
        ? SLOT_W'(SLOT_DEF_PORT + int'(frm_q.ingress_port)) : SLOT_W'(SLOT_DEF_COMMON);
    wire logic [SLOT_W-1:0] rsp_slot = lkp_rsp_in.hit ? SLOT_W'(lkp_rsp_in.index) : def_slot;
    wire logic cnt_zero = entry_hit_counter_q[rsp_slot] == HIT_W'(0);
    wire logic once_copy = rsp_act[ACT_ONCE_BIT] && cnt_zero; // R11 R12
    wire logic rsp_copy = rsp_act[ACT_COPY_BIT] || once_copy; // R13

    // apb decode
    wire logic apb_setup = psel_in && !penable_in;
    wire logic apb_wr = psel_in && penable_in && pready_q && pwrite_in;
    wire logic in_port_area = (paddr_in >= REG_DEF_PORT_BASE) && (paddr_in < REG_DEF_PORT_END)
        && (paddr_in[1:0] == 2'h0);
    wire logic [APB_AW-1:0] port_ofs = paddr_in - REG_DEF_PORT_BASE;
    wire logic [PORT_W-1:0] port_idx = port_ofs[PORT_W+1:2];
    wire logic hit_sel_ok = int'(hit_sel_q) < NUM_SLOTS;
    wire logic addr_ok = in_port_area || (paddr_in == REG_MIRROR)
        || (paddr_in == REG_DEF_COMMON) || (paddr_in == REG_HIT_SEL)
        || (paddr_in == REG_ENTRY_HIT_COUNTER) || (paddr_in == REG_FRAMES);
    wire logic hit_clr = apb_wr && (paddr_in == REG_ENTRY_HIT_COUNTER) && hit_sel_ok; // R12
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0;
        if (in_port_area)
            rd_mux = 32'(def_port_q[port_idx]);
        else if (paddr_in == REG_MIRROR)
            rd_mux = 32'(mirror_q);
        else if (paddr_in == REG_DEF_COMMON)
            rd_mux = 32'(def_common_q);
        else if (paddr_in == REG_HIT_SEL)
            rd_mux = 32'(hit_sel_q);
        else if ((paddr_in == REG_ENTRY_HIT_COUNTER) && hit_sel_ok)
            rd_mux = 32'(entry_hit_counter_q[hit_sel_q]);
        else if (paddr_in == REG_FRAMES)
            rd_mux = frames_q;
    end

    // mask mode application
    function automatic logic [NUM_PORTS-1:0] acl_apply_mask(
        input logic [ACT_W-1:0] act,
        input logic [NUM_PORTS-1:0] cur,
        input logic [NUM_PORTS-1:0] prior
    );
        logic [NUM_PORTS-1:0] pmask;
        pmask = act[ACT_MASK_LSB +: NUM_PORTS]; // R23
        case (act[ACT_MODE_LSB +: 2])
            MM_NONE: acl_apply_mask = cur; // R15
            MM_PERMIT: acl_apply_mask = cur & pmask; // R15
            MM_POLICY: acl_apply_mask = prior & pmask; // R16
            MM_REDIRECT: acl_apply_mask = pmask; // R17
            default: acl_apply_mask = cur;
        endcase
    endfunction : acl_apply_mask

    // combined decision of both lookups
    wire logic [NUM_PORTS-1:0] dest0 = frm_q.dmac_set & frm_q.prior_set;
    wire logic [NUM_PORTS-1:0] dest1 = acl_apply_mask(act1_q, dest0, frm_q.prior_set);
    wire logic [NUM_PORTS-1:0] dest2 = acl_apply_mask(act2_q, dest1, frm_q.prior_set);
    wire logic [CPU_Q_W-1:0] q1 = act1_q[ACT_QU_LSB +: CPU_Q_W]; // R14
    wire logic [CPU_Q_W-1:0] q2 = act2_q[ACT_QU_LSB +: CPU_Q_W]; // R14
    wire logic [CPU_Q_W-1:0] q_pick = (copy1_q && copy2_q) ? ((q1 > q2) ? q1 : q2)
        : (copy1_q ? q1 : q2);
    wire logic mirror_any = act1_q[ACT_MIRROR_BIT] || act2_q[ACT_MIRROR_BIT]; // R19
    acl_dec_type dec_d;

    always_comb
    begin
        dec_d.dest_set = dest2;
        dec_d.cpu_member = frm_q.cpu_member; // R18
        dec_d.cpu_copy = copy1_q || copy2_q; // R11 R13
        dec_d.cpu_queue = q_pick;
        dec_d.mirror_ports = mirror_any ? mirror_q : NUM_PORTS'(0); // R19
        dec_d.learning_inhibit = act1_q[ACT_LRN_BIT] || act2_q[ACT_LRN_BIT]; // R20
        dec_d.police_en = act1_q[ACT_POL_BIT]; // R21
        dec_d.policer_select = act1_q[ACT_PIDX_LSB +: PIDX_W]; // R22
    end

    // sequencing of the two lookups
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (frm_valid_in) state_d = ST_REQ1;
            ST_REQ1: state_d = ST_WAIT1; // R7
            ST_WAIT1: if (lkp_rsp_valid_in) state_d = ST_REQ2; // R7
            ST_REQ2: state_d = ST_WAIT2; // R7
            ST_WAIT2: if (lkp_rsp_valid_in) state_d = ST_DONE;
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_q <= ST_IDLE;
            rdy_q <= 1'b0;
            req_q <= 1'b0;
            first_q <= 1'b0;
            key_q <= '0;
            frm_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            rdy_q <= state_d == ST_IDLE;
            req_q <= (state_q == ST_REQ1) || (state_q == ST_REQ2);
            first_q <= (state_q == ST_REQ1) || (state_q == ST_WAIT1);
            if ((state_q == ST_IDLE) && frm_valid_in)
                frm_q <= frm_in;
            if (state_q == ST_REQ1)
                key_q <= key_sel;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            act1_q <= '0;
            act2_q <= '0;
            copy1_q <= 1'b0;
            copy2_q <= 1'b0;
        end
        else if (rsp_take && rsp_first)
        begin
            act1_q <= rsp_act;
            copy1_q <= rsp_copy;
        end
        else if (rsp_take)
        begin
            act2_q <= rsp_act;
            copy2_q <= rsp_copy;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            dec_valid_q <= 1'b0;
            dec_q <= '0;
            frames_q <= 32'h0;
        end
        else
        begin
            dec_valid_q <= state_q == ST_DONE;
            if (state_q == ST_DONE)
            begin
                dec_q <= dec_d;
                frames_q <= frames_q + 32'h1;
            end
        end
    end

    // hit counters, a clear together with an increment leaves one
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
                entry_hit_counter_q[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
            begin
                if (rsp_take && (int'(rsp_slot) == i))
                begin
                    if (hit_clr && (int'(hit_sel_q) == i))
                        entry_hit_counter_q[i] <= HIT_W'(1); // R12
                    else if (entry_hit_counter_q[i] != '1)
                        entry_hit_counter_q[i] <= entry_hit_counter_q[i] + HIT_W'(1); // R11
                end
                else if (hit_clr && (int'(hit_sel_q) == i))
                    entry_hit_counter_q[i] <= '0; // R12
            end
        end
    end

    // software registers
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            mirror_q <= '0;
            def_common_q <= '0;
            hit_sel_q <= '0;
            for (int p = 0; p < NUM_PORTS; p++)
                def_port_q[p] <= '0;
        end
        else if (apb_wr)
        begin
            if (in_port_area)
                def_port_q[port_idx] <= pwdata_in[ACT_W-1:0]; // R8
            if (paddr_in == REG_MIRROR)
                mirror_q <= pwdata_in[NUM_PORTS-1:0];
            if (paddr_in == REG_DEF_COMMON)
                def_common_q <= pwdata_in[ACT_W-1:0]; // R9
            if (paddr_in == REG_HIT_SEL)
                hit_sel_q <= pwdata_in[SLOT_W-1:0];
        end
    end

    // apb answer: one wait-free access phase
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup && !addr_ok;
            prdata_q <= (apb_setup && !pwrite_in) ? rd_mux : 32'h0;
        end
    end

    assign frm_ready_out = rdy_q;
    assign lkp_req_out = req_q;
    assign lkp_first_out = first_q;
    assign lkp_key_out = key_q;
    assign dec_valid_out = dec_valid_q;
    assign dec_out = dec_q;
    assign pready_out = pready_q;
    assign prdata_out = prdata_q;
    assign pslverr_out = pslverr_q;
endmodule : acl_key_action_decode

// [verification/acl_key_action_decode_asserts.sv]
// concurrent checks on the acl classifier stage ports
`timescale 1ns/100ps
module acl_kad_asserts
    import acl_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // frame side
    input wire logic frm_valid_in,
    input wire acl_frame_type frm_in,
    input wire logic frm_ready_out,
    // lookup side
    input wire logic lkp_req_out,
    input wire logic lkp_first_out,
    input wire logic [KEY_W-1:0] lkp_key_out,
    input wire logic lkp_rsp_valid_in,
    // decision side
    input wire logic dec_valid_out
);
    wire logic take = frm_valid_in && frm_ready_out;
    wire logic v6_take = take && !frm_in.use_custom;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_take_to_req: assert property (take |-> ##2 (lkp_req_out && lkp_first_out))
        else $error("first lookup request late");
    a_ready_drops: assert property (take |=> !frm_ready_out)
        else $error("frame ready stayed high after take");
    a_hop_flag: assert property (v6_take |-> ##2
        lkp_key_out[KEY_TTL_BIT] == ($past(frm_in.hop_limit, 2) != 8'h0)
        && lkp_key_out[KEY_TOS_LSB+:8] == $past(frm_in.traffic_class, 2))
        else $error("hop flag or traffic class misplaced");
    a_addr_place: assert property (v6_take |-> ##2
        lkp_key_out[KEY_DIP_LSB+:128] == $past(frm_in.dip, 2)
        && lkp_key_out[KEY_SIP_LSB+:128] == $past(frm_in.sip, 2))
        else $error("addresses misplaced in key");
    a_eq_flag: assert property (v6_take |-> ##2
        lkp_key_out[KEY_EQ_BIT] == ($past(frm_in.dip, 2) == $past(frm_in.sip, 2)))
        else $error("address equality flag wrong");
    a_tail_place: assert property (v6_take |-> ##2
        lkp_key_out[KEY_NXT_LSB+:8] == $past(frm_in.next_header, 2)
        && lkp_key_out[KEY_L4_LSB+:56] == $past(frm_in.l4_bytes, 2))
        else $error("next header or payload bytes misplaced");
    a_cust_sel: assert property (take && frm_in.use_custom |-> ##2
        lkp_key_out[KEY_CUST_SEL_BIT] == $past(frm_in.after_source_mac_offset, 2))
        else $error("custom selector bit wrong");
    a_second_req: assert property (lkp_rsp_valid_in && lkp_first_out |-> ##2
        (lkp_req_out && !lkp_first_out))
        else $error("second lookup request late");
    a_dec_timing: assert property (dec_valid_out |->
        $past(lkp_rsp_valid_in, 2) && !$past(lkp_first_out, 2))
        else $error("decision not two cycles after second answer");
    a_req_pulse: assert property (lkp_req_out |=> !lkp_req_out)
        else $error("lookup request longer than one cycle");
    a_ready_back: assert property (dec_valid_out |-> frm_ready_out)
        else $error("frame ready not back after decision");
endmodule : acl_kad_asserts

bind acl_key_action_decode acl_kad_asserts u_acl_kad_asserts (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .frm_valid_in(frm_valid_in),
    .frm_in(frm_in),
    .frm_ready_out(frm_ready_out),
    .lkp_req_out(lkp_req_out),
    .lkp_first_out(lkp_first_out),
    .lkp_key_out(lkp_key_out),
    .lkp_rsp_valid_in(lkp_rsp_valid_in),
    .dec_valid_out(dec_valid_out)
);

// [verification/acl_lookup_model.sv]
// lookup engine model answering both lookups of a frame
`timescale 1ns/100ps
module acl_lookup_model
    import acl_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // request from the classifier
    input wire logic req_in,
    input wire logic first_in,
    // answers set by the bench
    input wire logic hit1_in,
    input wire logic hit2_in,
    input wire logic [IDX_W-1:0] idx1_in,
    input wire logic [IDX_W-1:0] idx2_in,
    input wire logic [ACT_W-1:0] act1_in,
    input wire logic [ACT_W-1:0] act2_in,
    input wire logic [3:0] dly_in,
    // answer to the classifier
    output logic rsp_valid_out,
    output acl_rsp_type rsp_out
);
    logic pend_q, first_q, give;
    logic [3:0] cnt_q;
    acl_rsp_type ans;
    assign ans = (req_in ? first_in : first_q) ? {hit1_in, idx1_in, act1_in}
        : {hit2_in, idx2_in, act2_in};
    assign give = req_in ? (dly_in == 4'h0) : (pend_q && cnt_q == 4'h1);
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rsp_valid_out <= 1'h0;
            rsp_out <= '0;
            pend_q <= 1'h0;
            first_q <= 1'h0;
            cnt_q <= 4'h0;
        end
        else
        begin
            rsp_valid_out <= give;
            rsp_out <= give ? ans : ~rsp_out;
            if (req_in)
            begin
                first_q <= first_in;
                cnt_q <= dly_in;
                pend_q <= (dly_in != 4'h0);
            end
            else if (pend_q)
            begin
                cnt_q <= cnt_q - 4'h1;
                pend_q <= (cnt_q != 4'h1);
            end
        end
    end
endmodule : acl_lookup_model

// [verification/tb_acl_key_action_decode.sv]
// self-checking bench for the acl classifier stage
`timescale 1ns/100ps
module tb_acl_key_action_decode import acl_pkg::*;;
    logic clk_in = 1'h0;
    logic reset_n_in = 1'h0;
    logic frm_valid = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic hit1 = 1'h1, hit2 = 1'h1;
    logic [IDX_W-1:0] idx1 = '0, idx2 = '0;
    logic [ACT_W-1:0] act1 = '0, act2 = '0;
    logic [3:0] dly = 4'h0;
    acl_frame_type f = '0;
    acl_frame_type f0, fr;
    acl_rsp_type rsp;
    logic rsp_valid, lkp_req, lkp_first, frm_ready, dec_valid, pready, pslverr, er;
    logic [31:0] prdata, rd;
    logic [KEY_W-1:0] lkp_key;
    acl_dec_type dec_o, dec, e;
    logic [1:0] mm;
    logic [8:0] pi;
    int errors = 0, num_checks = 0;

    acl_key_action_decode u_acl_key_action_decode (
        .clk_in(clk_in), .reset_n_in(reset_n_in),
        .frm_valid_in(frm_valid), .frm_in(f), .frm_ready_out(frm_ready),
        .lkp_req_out(lkp_req), .lkp_first_out(lkp_first), .lkp_key_out(lkp_key),
        .lkp_rsp_valid_in(rsp_valid), .lkp_rsp_in(rsp),
        .dec_valid_out(dec_valid), .dec_out(dec_o),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr)
    );
    acl_lookup_model u_acl_lookup_model (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(lkp_req), .first_in(lkp_first),
        .hit1_in(hit1), .hit2_in(hit2), .idx1_in(idx1), .idx2_in(idx2),
        .act1_in(act1), .act2_in(act2), .dly_in(dly),
        .rsp_valid_out(rsp_valid), .rsp_out(rsp)
    );

    initial
    begin
        forever #2 clk_in = ~clk_in;
    end

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input string n, input logic [KEY_W-1:0] x, g);
        num_checks++;
        if (g !== x)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'h1;
        do @(posedge clk_in); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    function automatic logic [ACT_W-1:0] mk(input logic [9:0] lo, input logic [8:0] p,
        input logic [10:0] m);
        mk = {m, 1'h0, p, lo};
    endfunction : mk

    function automatic acl_dec_type mkd(input logic [10:0] d, input logic c, cp,
        input logic [2:0] q, input logic [10:0] mi, input logic l, p, input logic [8:0] s);
        mkd = {d, c, cp, q, mi, l, p, s};
    endfunction : mkd

    function automatic logic [10:0] fw(input logic [ACT_W-1:0] a, input logic [10:0] c,
        input logic [10:0] pr);
        case (a[ACT_MODE_LSB+:2])
            MM_PERMIT: fw = c & a[ACT_MASK_LSB+:NUM_PORTS];
            MM_POLICY: fw = pr & a[ACT_MASK_LSB+:NUM_PORTS];
            MM_REDIRECT: fw = a[ACT_MASK_LSB+:NUM_PORTS];
            default: fw = c;
        endcase
    endfunction : fw

    task automatic send(input acl_frame_type fs);
        int s;
        logic [KEY_W-1:0] x;
        logic [KEY_W-1:0] kg;
        x = '0;
        @(posedge clk_in);
        frm_valid <= 1'h1;
        f <= fs;
        do @(posedge clk_in); while (frm_ready !== 1'h1);
        frm_valid <= 1'h0;
        do @(posedge clk_in); while (!(lkp_req === 1'h1 && lkp_first === 1'h1));
        kg = lkp_key;
        do @(posedge clk_in); while (dec_valid !== 1'h1);
        dec = dec_o;
        if (fs.use_custom)
        begin
            s = (fs.after_source_mac_offset ? 12 : 34) + 4 * fs.vlan_tags;
            x[44:0] = {fs.after_source_mac_offset, fs.common};
            for (int k = 0; k < 40; k++)
                x[45+8*k+:8] = fs.bytes[8*(s+k)+:8];
        end
        else
            x = {fs.l4_bytes, fs.next_header, fs.dip == fs.sip, fs.sip, fs.dip,
                fs.traffic_class, fs.hop_limit != 8'h0, fs.common};
        chk("key", x, kg);
    endtask : send

    initial
    begin
        #40000;
        errors++;
        wrap_up();
    end

    initial
    begin
        f0 = '0;
        f0.common = 44'hA5C3E1F0B27;
        f0.ingress_port = 4'h3;
        f0.traffic_class = 8'h5C;
        f0.dip = 128'h2001_0DB8_0000_0000_0000_0000_0000_0001;
        f0.sip = 128'hFE80_0000_0000_0000_0211_22FF_FE33_4455;
        f0.next_header = 8'h3A;
        f0.l4_bytes = 56'h8000123456789A;
        f0.dmac_set = 11'h3F0;
        f0.prior_set = 11'h7CF;
        f0.cpu_member = 1'h1;
        for (int i = 0; i < FRAME_BYTES; i++)
            f0.bytes[8*i+:8] = 8'(i * 7 + 3);
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'h1;
        apb(1'h1, REG_MIRROR, 32'h5A5);
        apb(1'h0, 8'hF0, 32'h0);
        chk("unmapped err", 1'h1, er);
        chk("unmapped data", 32'h0, rd);
        for (int m = 0; m < 4; m++)
        begin
            mm = 2'(m);
            pi = mm[0] ? 9'h0 : 9'h1A5;
            fr = f0;
            fr.hop_limit = 8'(m);
            fr.sip = mm[1] ? f0.dip : f0.sip;
            fr.cpu_member = mm[0];
            act1 <= mk({~mm[0], mm[1], mm[0], mm, 3'(m + 2), 2'h2}, pi, 11'h15A);
            send(fr);
            e = mkd(fw(act1, 11'h3C0, 11'h7CF), mm[0], 1'h1, 3'(m + 2),
                mm[0] ? 11'h5A5 : 11'h0, mm[1], ~mm[0], pi);
            chk("mode decision", e, dec);
        end
        act1 <= '0;
        act2 <= mk({2'h3, 1'h0, MM_REDIRECT, 5'h0}, 9'h0F3, 11'h0AA);
        send(f0);
        e = mkd(11'h0AA, 1'h1, 1'h0, 3'h0, 11'h0, 1'h1, 1'h0, 9'h0);
        chk("second lookup", e, dec);
        apb(1'h1, REG_DEF_PORT_BASE + 8'h0C, 32'(mk({3'h1, MM_NONE, 3'h5, 2'h2}, 9'h0, 11'h0)));
        apb(1'h1, REG_DEF_PORT_BASE + 8'h1C, 32'(mk({3'h4, MM_PERMIT, 5'h0}, 9'h033, 11'h1C3)));
        apb(1'h1, REG_DEF_COMMON, 32'(mk({3'h2, MM_NONE, 5'h0}, 9'h0, 11'h0)));
        hit1 <= 1'h0;
        hit2 <= 1'h0;
        act1 <= mk(10'h3FF, 9'h1FF, 11'h7FF);
        act2 <= mk(10'h3FF, 9'h1FF, 11'h7FF);
        send(f0);
        e = mkd(11'h3C0, 1'h1, 1'h1, 3'h5, 11'h5A5, 1'h1, 1'h0, 9'h0);
        chk("port default", e, dec);
        fr = f0;
        fr.ingress_port = 4'h7;
        send(fr);
        e = mkd(11'h1C0, 1'h1, 1'h0, 3'h0, 11'h0, 1'h1, 1'h1, 9'h033);
        chk("other port default", e, dec);
        hit1 <= 1'h1;
        hit2 <= 1'h1;
        idx1 <= 6'h05;
        idx2 <= 6'h09;
        dly <= 4'h3;
        act1 <= mk({5'h0, 3'h6, 2'h1}, 9'h0, 11'h0);
        act2 <= '0;
        apb(1'h1, REG_HIT_SEL, 32'h5);
        apb(1'h0, REG_ENTRY_HIT_COUNTER, 32'h0);
        chk("hit count", 32'h0, rd);
        for (int i = 0; i < 3; i++)
        begin
            if (i == 2)
                apb(1'h1, REG_ENTRY_HIT_COUNTER, 32'h0);
            send(f0);
            chk("single copy", i != 1, dec.cpu_copy);
            if (i == 1)
                apb(1'h0, REG_ENTRY_HIT_COUNTER, 32'h0);
            if (i == 1)
                chk("hit count", 32'h2, rd);
        end
        dly <= 4'h0;
        for (int t = 0; t < 6; t++)
        begin
            fr = f0;
            fr.use_custom = 1'h1;
            fr.after_source_mac_offset = t[0];
            fr.vlan_tags = 2'(t / 2);
            send(fr);
        end
        wrap_up();
    end
endmodule : tb_acl_key_action_decode
